/* hdl/sram_ctl.sv */
// Synchronous control front end of a pipelined burst SRAM
`timescale 1ns/1ps
`include "sram_ctl_map.svh"

// Operation
// R01: Address captured on qualified rising edge
// R02: Active-low lane selects, only with write
// R03: Write enable low starts write, qualified
// R04: Advance high steps burst counter
// R05: Advance low loads new start address
// R06: Host loads fresh address after deselect
// R07: Qualifier high ignores the clock edge
// R08: First select active low, sampled
// R09: Second select active high, sampled
// R10: Output enable low allows data drive
// R11: Float during write, first-after-deselect, deselected
// R12: Qualifier high holds state, not deselect
// R13: Read returns location from preceding edge
// R14: Strap picks interleaved or linear order
// R15: Selected only when low, high, low
// R16: Two low bits count, upper bits fixed
module sram_ctl #(
    parameter int ADDR_W = `ADDR_BITS,
    parameter int LANES = `LANE_COUNT,
    parameter int LANE_W = `LANE_DATA_BITS,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Synchronous control pins
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [LANES-1:0] lane_write_sel_n,
    input wire logic write_en_n,
    input wire logic advance_or_load,
    input wire logic clock_qualifier_n,
    input wire logic select_first_n,
    input wire logic select_second,
    input wire logic select_third_n,
    // Asynchronous pins
    input wire logic output_enable_n,
    input wire logic burst_order_strap,
    // Data and parity pins
    input wire logic [LANES*LANE_W-1:0] dq_in,
    input wire logic [LANES-1:0] parity_lines_in,
    output logic [LANES*LANE_W-1:0] dq_out,
    output logic [LANES-1:0] parity_lines_out,
    output logic dq_oe_n,
    // Array request stream
    output logic req_valid,
    input wire logic req_ready,
    output logic req_write,
    output logic [LANES-1:0] req_lanes,
    output logic [ADDR_W-1:0] req_addr,
    output logic [LANES*LANE_W-1:0] req_dq,
    output logic [LANES-1:0] req_parity,
    // Array read return
    input wire logic rsp_valid,
    input wire logic [LANES*LANE_W-1:0] rsp_dq,
    input wire logic [LANES-1:0] rsp_parity,
    // Capture stalled while the queue is full
    output logic accept_ready
);
    localparam int BB = `BURST_BITS;
    localparam int DW = LANES * LANE_W + LANES;
    localparam int RW = 1 + LANES + ADDR_W + DW;

    stream_if #(.WIDTH(RW)) fill_if ();
    stream_if #(.WIDTH(RW)) drain_if ();

    sram_ctl_pkg::access_type state_r;
    sram_ctl_pkg::access_type state_nxt;
    sram_ctl_pkg::order_type order_r;
    sram_ctl_pkg::order_type order_nxt;
    logic [ADDR_W-1:BB] base_r;
    logic [ADDR_W-1:BB] base_nxt;
    logic [BB-1:0] start_r;
    logic [BB-1:0] start_nxt;
    logic [BB-1:0] step_r;
    logic [BB-1:0] step_nxt;
    logic [LANES-1:0] lanes_r;
    logic [LANES-1:0] lanes_nxt;
    logic pend_r;
    logic pend_nxt;
    logic pend_write_r;
    logic pend_write_nxt;
    logic [LANES-1:0] pend_lanes_r;
    logic [LANES-1:0] pend_lanes_nxt;
    logic [ADDR_W-1:0] pend_addr_r;
    logic [ADDR_W-1:0] pend_addr_nxt;
    logic first_r;
    logic first_nxt;
    logic rd_phase_r;
    logic rd_phase_nxt;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;
    logic oe_s1_r;
    logic oe_s2_r;
    logic mode_s1_r;
    logic mode_s2_r;
    logic go;
    logic selected;

    function automatic logic [BB-1:0] burst_low(input sram_ctl_pkg::order_type order,
                                               input logic [BB-1:0] start,
                                               input logic [BB-1:0] step);
        if (order == sram_ctl_pkg::order_interleaved) begin
            return start ^ step; // [R14]
        end
        return start + step; // [R14]
    endfunction

    // Edge counts only with qualifier low and room in the queue
    assign go = !clock_qualifier_n && fill_if.ready; // [R07] [R12]
    assign selected = !select_first_n && select_second && !select_third_n; // [R08] [R09] [R15]
    assign accept_ready = fill_if.ready;

    // Previous access enters the queue, writes with their data phase
    assign fill_if.valid = go && pend_r;
    assign fill_if.data = {pend_write_r, pend_lanes_r, pend_addr_r, dq_in, parity_lines_in}; // [R02]

    always_comb begin
        state_nxt = state_r;
        base_nxt = base_r;
        start_nxt = start_r;
        step_nxt = step_r;
        lanes_nxt = lanes_r;
        pend_nxt = pend_r;
        pend_write_nxt = pend_write_r;
        pend_lanes_nxt = pend_lanes_r;
        pend_addr_nxt = pend_addr_r;
        first_nxt = first_r;
        rd_phase_nxt = rd_phase_r;
        rdata_nxt = rsp_valid ? {rsp_dq, rsp_parity} : rdata_r; // [R13]
        order_nxt = rst ? sram_ctl_pkg::order_type'(mode_s2_r) : order_r; // [R14]
        if (go) begin
            first_nxt = 1'b0;
            rd_phase_nxt = pend_r && !pend_write_r;
            if (!advance_or_load) begin
                if (selected) begin
                    state_nxt = write_en_n ? sram_ctl_pkg::access_read : sram_ctl_pkg::access_write; // [R03]
                    base_nxt = addr[ADDR_W-1:BB]; // [R01] [R05] [R16]
                    start_nxt = addr[BB-1:0]; // [R01] [R05] [R16]
                    step_nxt = '0;
                    lanes_nxt = write_en_n ? '0 : ~lane_write_sel_n; // [R02]
                    first_nxt = (state_r == sram_ctl_pkg::access_desel); // [R11]
                end else begin
                    state_nxt = sram_ctl_pkg::access_desel;
                end
            end else if (state_r != sram_ctl_pkg::access_desel) begin
                step_nxt = step_r + 1'b1; // [R04] [R16]
            end
            pend_nxt = (state_nxt != sram_ctl_pkg::access_desel);
            pend_write_nxt = (state_nxt == sram_ctl_pkg::access_write);
            pend_lanes_nxt = lanes_nxt;
            pend_addr_nxt = {base_nxt, burst_low(order_r, start_nxt, step_nxt)}; // [R16]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= sram_ctl_pkg::access_desel;
            base_r <= '0;
            start_r <= '0;
            step_r <= '0;
            lanes_r <= '0;
            pend_r <= 1'b0;
            pend_write_r <= 1'b0;
            pend_lanes_r <= '0;
            pend_addr_r <= '0;
            first_r <= 1'b0;
            rd_phase_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            state_r <= state_nxt;
            base_r <= base_nxt;
            start_r <= start_nxt;
            step_r <= step_nxt;
            lanes_r <= lanes_nxt;
            pend_r <= pend_nxt;
            pend_write_r <= pend_write_nxt;
            pend_lanes_r <= pend_lanes_nxt;
            pend_addr_r <= pend_addr_nxt;
            first_r <= first_nxt;
            rd_phase_r <= rd_phase_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Strap is latched while reset is held and stays fixed afterwards
    always_ff @(posedge clk) begin
        order_r <= order_nxt;
    end

    // Two-flop synchronisers for the asynchronous pins
    always_ff @(posedge clk) begin
        if (rst) begin
            oe_s1_r <= `OE_N_RESET;
            oe_s2_r <= `OE_N_RESET;
        end else begin
            oe_s1_r <= output_enable_n;
            oe_s2_r <= oe_s1_r;
        end
    end

    // Strap synchroniser keeps running through reset so the latch sees the pin
    always_ff @(posedge clk) begin
        mode_s1_r <= burst_order_strap; // [R14]
        mode_s2_r <= mode_s1_r;
    end

    // Drive only in a read data phase, never when masked
    assign dq_oe_n = !(rd_phase_r && !oe_s2_r && !first_r && !pend_write_r
                       && state_r != sram_ctl_pkg::access_desel); // [R10] [R11]
    assign dq_out = rdata_r[DW-1:LANES];
    assign parity_lines_out = rdata_r[LANES-1:0];

    stream_fifo #(.WIDTH(RW), .DEPTH(DEPTH)) req_fifo (
        .clk(clk),
        .rst(rst),
        .fill(fill_if.snk),
        .drain(drain_if.src)
    );

    assign drain_if.ready = req_ready;
    assign req_valid = drain_if.valid;
    assign {req_write, req_lanes, req_addr, req_dq, req_parity} = drain_if.data;
endmodule

/* hdl/sram_ctl_map.svh */
// Constants for the pipelined SRAM control front end
`ifndef SRAM_CTL_MAP_SVH
`define SRAM_CTL_MAP_SVH

`define ADDR_BITS 19
`define LANE_COUNT 4
`define LANE_DATA_BITS 8
`define BURST_BITS 2
`define FIFO_DEPTH 16
`define ORDER_RESET 1'b1
`define OE_N_RESET 1'b1

`endif

/* hdl/sram_ctl_pkg.sv */
// Types for the pipelined SRAM control front end
package sram_ctl_pkg;

    // Gray-coded access state: deselected, read, write
    typedef enum logic [1:0] {
        access_desel = 2'b00,
        access_read = 2'b01,
        access_write = 2'b11
    } access_type;

    typedef enum logic {
        order_linear = 1'b0,
        order_interleaved = 1'b1
    } order_type;

endpackage

/* hdl/stream_if.sv */
// Valid/ready stream carrier between internal modules
`timescale 1ns/1ps
interface stream_if #(parameter int WIDTH = 8) ();
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

/* hdl/stream_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    stream_if.snk fill,
    // Draining side
    stream_if.src drain
);
    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] FULL_COUNT = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wr_ptr_r;
    logic [PW-1:0] wr_ptr_nxt;
    logic [PW-1:0] rd_ptr_r;
    logic [PW-1:0] rd_ptr_nxt;
    logic [PW:0] count_r;
    logic [PW:0] count_nxt;
    logic push;
    logic pop;

    assign fill.ready = (count_r != FULL_COUNT);
    assign drain.valid = (count_r != '0);
    assign drain.data = mem_r[rd_ptr_r];
    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        if (push) begin
            wr_ptr_nxt = (wr_ptr_r == LAST_SLOT) ? '0 : wr_ptr_r + 1'b1;
        end
        if (pop) begin
            rd_ptr_nxt = (rd_ptr_r == LAST_SLOT) ? '0 : rd_ptr_r + 1'b1;
        end
        case ({push, pop})
            2'b10: count_nxt = count_r + 1'b1;
            2'b01: count_nxt = count_r - 1'b1;
            default: count_nxt = count_r;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= fill.data;
        end
    end
endmodule

/* bench/sram_ctl_chk.sv */
// Concurrent checks on the SRAM control front end pins
`timescale 1ns/1ps
module sram_ctl_chk #(parameter int LANES = 4, parameter int LANE_W = 8) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control pins
    input wire logic clock_qualifier_n,
    input wire logic select_first_n,
    input wire logic select_second,
    input wire logic select_third_n,
    input wire logic advance_or_load,
    input wire logic write_en_n,
    input wire logic output_enable_n,
    // Data and request side
    input wire logic dq_oe_n,
    input wire logic [LANES*LANE_W-1:0] dq_out,
    input wire logic rsp_valid,
    input wire logic [LANES*LANE_W-1:0] rsp_dq,
    input wire logic accept_ready,
    input wire logic req_valid
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire go = !clock_qualifier_n && accept_ready;
    wire sel = !select_first_n && select_second && !select_third_n;
    sequence s_write;
        go && sel && !advance_or_load && !write_en_n;
    endsequence
    sequence s_desel;
        go && !sel && !advance_or_load;
    endsequence
    a_reset_idle: assert property (disable iff (1'b0) rst |=> !req_valid && dq_oe_n && accept_ready)
        else $error("outputs not idle after reset");
    a_write_push: assert property (s_write ##1 go |=> req_valid)
        else $error("write access not queued");
    a_write_float: assert property (s_write |=> dq_oe_n)
        else $error("data pins driven in write");
    a_desel_float: assert property (s_desel |=> dq_oe_n)
        else $error("data pins driven while deselected");
    a_adv_ignored: assert property (s_desel ##1 (go && advance_or_load) |=> dq_oe_n)
        else $error("advance left the deselected state");
    a_oe_mask: assert property (output_enable_n [*3] |-> dq_oe_n)
        else $error("data pins driven with output enable high");
    a_held_push: assert property ($rose(req_valid) |-> $past(go))
        else $error("access queued on an ignored edge");
    a_read_return: assert property (rsp_valid |=> dq_out == $past(rsp_dq))
        else $error("read data not presented");
endmodule

/* bench/array_model.sv */
// Behavioural storage array on the far side of the request stream
`timescale 1ns/1ps
module array_model (
    // Clock, reset and pacing
    input wire logic clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic slow,
    // Request stream
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [3:0] req_lanes,
    input wire logic [18:0] req_addr,
    input wire logic [35:0] req_word,
    // Read return
    output logic rsp_valid = 1'b0,
    output logic [35:0] rsp_word = 36'h0
);
    logic [35:0] store [logic [18:0]];
    logic [35:0] w;
    logic tick = 1'b0;
    assign req_ready = !stall && (!slow || tick);
    always @(posedge clk) begin
        tick <= !tick;
        rsp_valid <= 1'b0;
        rsp_word <= ~rsp_word;  // Idle return lines keep moving so stale data cannot pass
        if (rst)
            store.delete();
        else if (req_valid && req_ready) begin
            w = store.exists(req_addr) ? store[req_addr] : 36'h0;
            for (int i = 0; i < 4; i++) if (req_write && req_lanes[i]) begin
                w[8*i +: 8] = req_word[8*i +: 8];
                w[32 + i] = req_word[32 + i];
            end
            store[req_addr] = w;
            rsp_valid <= !req_write;
            rsp_word <= w;
        end
    end
endmodule

/* bench/pipelined_sram_control_pins_test.sv */
// Self-checking bench for the SRAM control front end
`timescale 1ns/1ps
bind sram_ctl sram_ctl_chk #(.LANES(LANES), .LANE_W(LANE_W)) u_chk (.*);
module pipelined_sram_control_pins_test;
    logic clk = 1'b0, rst = 1'b1, stall = 1'b0, slow = 1'b0, q_n = 1'b0, st = 1'b0, pend = 1'b0, pw;
    logic write_en_n = 1'b1, advance_or_load = 1'b0, clock_qualifier_n = 1'b0, select_first_n = 1'b1;
    logic select_second = 1'b0, select_third_n = 1'b1, output_enable_n = 1'b0, burst_order_strap = 1'b1;
    logic dq_oe_n, req_valid, req_ready, req_write, rsp_valid, accept_ready;
    logic [3:0] lane_write_sel_n = 4'hf, parity_lines_in = 4'h0, parity_lines_out, req_lanes, req_parity, pl;
    logic [18:0] addr = 19'h0, req_addr, base, pa;
    logic [31:0] dq_in = 32'h0, dq_out, req_dq, seed = 32'h00015e65;
    wire [31:0] rsp_dq;
    wire [3:0] rsp_parity;
    logic [1:0] k;
    logic [59:0] expq[$], gotq[$];
    int err_total = 0, total_checks = 0;
    sram_ctl u_dut (.*);
    array_model u_array (.clk, .rst, .stall, .slow, .req_valid, .req_ready, .req_write, .req_lanes, .req_addr,
        .req_word({req_parity, req_dq}), .rsp_valid, .rsp_word({rsp_parity, rsp_dq}));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (req_valid && req_ready)
        gotq.push_back({req_write, req_lanes, req_addr, req_parity, req_dq});
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [18:0] burst(input logic [18:0] b, input logic [1:0] n);
        return {b[18:2], burst_order_strap ? b[1:0] ^ n : b[1:0] + n};
    endfunction
    function automatic logic [35:0] merge(input logic [59:0] e);
        merge = 36'h0;
        for (int i = 0; i < 4; i++) if (e[55 + i]) begin
            merge[8*i +: 8] = e[8*i +: 8];
            merge[32 + i] = e[32 + i];
        end
    endfunction
    task automatic check(input logic [59:0] seen, input logic [59:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic step(input logic [2:0] cs, input logic adv, we_n, input logic [18:0] a, input logic [3:0] ln);
        @(negedge clk);
        seed = nxt(seed);
        {select_first_n, select_second, select_third_n, clock_qualifier_n} = {cs, q_n};
        {advance_or_load, write_en_n, addr, lane_write_sel_n} = {adv, we_n, a, ln};
        {parity_lines_in, dq_in} = {seed[7:4], seed};
        if (!q_n) begin
            if (pend)
                expq.push_back({pw, pl, pa, parity_lines_in, dq_in});
            if (!adv)
                {st, pw, pl, base, k} = {cs == 3'h2, !we_n, we_n ? 4'h0 : ~ln, a, 2'h0};
            else
                k++;
            pa = burst(base, k);
            pend = st;
        end
    endtask
    task automatic restart(input logic strap);
        {rst, burst_order_strap, slow, output_enable_n} = {1'b1, strap, !strap, !strap};
        repeat (12) @(negedge clk);
        rst = 1'b0;
        {pend, st} = 2'h0;
        expq.delete();
        gotq.delete();
    endtask
    task automatic drain;
        int i;
        for (i = 0; i < 300 && req_valid !== 1'b0; i++)
            @(negedge clk);
        if (i == 300) begin
            check(60'h1, 60'h0);
            give_verdict();
        end
        repeat (4) @(negedge clk);
    endtask
    initial begin
        logic [18:0] a;
        logic [59:0] mk;
        for (int m = 1; m >= 0; m--) begin
            restart(m[0]);
            a = seed[18:0];
            step(3'h2, 1'b0, 1'b0, a, seed[22:19]);
            step(3'h2, 1'b0, 1'b1, a, 4'hf);
            step(3'h6, 1'b0, 1'b1, a, 4'hf);
            drain();
            check(60'({parity_lines_out, dq_out}), 60'(merge(expq[0])));
            step(3'h2, 1'b1, 1'b1, ~a, 4'hf);
            for (int c = 0; c < 8; c++)
                step(c[2:0], 1'b0, 1'b1, a + 19'(c), 4'hf);
            step(3'h2, 1'b0, 1'b1, a ^ 19'h8, 4'hf);
            q_n = 1'b1;
            repeat (3) step(3'h2, 1'b0, 1'b0, ~a, 4'h0);
            q_n = 1'b0;
            step(3'h2, 1'b0, 1'b1, a, 4'hf);
            repeat (4) begin
                step(3'h2, 1'b1, 1'b1, ~a, 4'hf);
                check(60'(dq_oe_n), 60'(output_enable_n));
            end
            step(3'h6, 1'b0, 1'b1, a, 4'hf);
            drain();
            check(60'(gotq.size()), 60'(expq.size()));
            foreach (expq[i]) begin
                mk = {24'hffffff, {36{expq[i][59]}}};
                check(gotq[i] & mk, expq[i] & mk);
            end
        end
        stall = 1'b1;
        gotq.delete();
        for (int n = 0; n < 20; n++)
            step(3'h2, 1'b0, 1'b1, 19'(n), 4'hf);
        step(3'h6, 1'b0, 1'b1, a, 4'hf);
        check(60'(accept_ready), 60'h0);
        stall = 1'b0;
        drain();
        check(60'(gotq.size()), 60'h11);
        foreach (gotq[i])
            check(60'(gotq[i][54:36]), 60'(i));
        give_verdict();
    end
endmodule
